/* File: tmw_pkg.sv */
package tmw_pkg;
    localparam logic [5:0] OFS_CTRL_B = 6'h2e;
    localparam logic [5:0] OFS_CTRL_A = 6'h2f;
    localparam logic [5:0] OFS_CNT_L = 6'h2c;
    localparam logic [5:0] OFS_CNT_H = 6'h2d;
    localparam logic [5:0] OFS_CMPA_L = 6'h2a;
    localparam logic [5:0] OFS_CMPA_H = 6'h2b;
    localparam logic [5:0] OFS_CMPB_L = 6'h28;
    localparam logic [5:0] OFS_CMPB_H = 6'h29;
    localparam logic [5:0] OFS_CAP_L = 6'h24;
    localparam logic [5:0] OFS_CAP_H = 6'h25;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [9:0] PRESCALE_MAX = 10'h3ff;

    typedef enum logic [1:0] {TMW_NORMAL, TMW_CTC, TMW_FAST, TMW_PHASE} tmw_kind_t;
    typedef enum logic [1:0] {TMW_TOP_FIXED, TMW_TOP_CMPA, TMW_TOP_CAP} tmw_topsrc_t;
    typedef enum logic [1:0] {TMW_UPD_NOW, TMW_UPD_TOP, TMW_UPD_BOTTOM} tmw_upd_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmw_bus_t;

    typedef struct packed {
        tmw_kind_t kind;
        tmw_topsrc_t topsrc;
        tmw_upd_t upd;
        logic ovf_at_bottom;
        logic [15:0] fixed_top;
    } tmw_mode_t;
endpackage

/* File: tmw_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tmw_timer (
    input wire logic core_clk,
    input wire logic nrst,
    input wire tmw_pkg::tmw_bus_t bus,
    output logic [7:0] rdata,
    input wire logic ext_clk_pin,
    input wire logic capture_input_pin,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic wave_a_pin_override,
    output logic wave_b_pin_override,
    output logic overflow_flag,
    output logic capture_input_enable
);
    logic [7:0] ctrl_a_reg, ctrl_a_next, ctrl_b_reg, ctrl_b_next, hold_reg, hold_next;
    logic [15:0] cnt_reg, cnt_next, cmpa_reg, cmpa_next, cmpb_reg, cmpb_next;
    logic [15:0] bufa_reg, bufa_next, bufb_reg, bufb_next, cap_reg, cap_next;
    logic [9:0] pre_reg, pre_next;
    logic down_reg, down_next, wa_reg, wa_next, wb_reg, wb_next;
    logic ext_reg, ext_next, cap_pin_reg, cap_pin_next, block_reg, block_next;
    logic [3:0] wave_mode_select;
    logic [1:0] chan_a_output_mode, chan_b_output_mode;
    logic [2:0] clock_source_select;
    logic wave_mode_top_bit, tick, at_top, at_bottom, ovf_evt;
    logic [15:0] top;
    logic match_a, match_b, ext_fall, ext_rise, cap_edge;
    tmw_pkg::tmw_mode_t mode;

    assign chan_a_output_mode = ctrl_a_reg[7:6];
    assign chan_b_output_mode = ctrl_a_reg[5:4];
    assign wave_mode_select = {ctrl_b_reg[4:3], ctrl_a_reg[1:0]};
    assign wave_mode_top_bit = wave_mode_select[3];
    assign clock_source_select = ctrl_b_reg[2:0];

    // Mode decode; reserved mode 13 counts as plain normal mode.
    always_comb
    begin
        mode = '{tmw_pkg::TMW_NORMAL, tmw_pkg::TMW_TOP_FIXED, tmw_pkg::TMW_UPD_NOW,
                 1'b0, tmw_pkg::TOP_MAX};
        unique case (wave_mode_select)
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb:
            begin
                mode.kind = tmw_pkg::TMW_PHASE;
                mode.upd = tmw_pkg::TMW_UPD_TOP;
                mode.ovf_at_bottom = 1'b1;
            end
            4'h4, 4'hc:
                mode.kind = tmw_pkg::TMW_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf:
            begin
                mode.kind = tmw_pkg::TMW_FAST;
                mode.upd = tmw_pkg::TMW_UPD_TOP;
            end
            4'h8, 4'h9:
            begin
                mode.kind = tmw_pkg::TMW_PHASE;
                mode.upd = tmw_pkg::TMW_UPD_BOTTOM;
                mode.ovf_at_bottom = 1'b1;
            end
            default:
                mode.kind = tmw_pkg::TMW_NORMAL;
        endcase
        unique case (wave_mode_select[1:0])
            2'h1: mode.fixed_top = tmw_pkg::TOP_8BIT;
            2'h2: mode.fixed_top = tmw_pkg::TOP_9BIT;
            2'h3: mode.fixed_top = tmw_pkg::TOP_10BIT;
            default: mode.fixed_top = tmw_pkg::TOP_MAX;
        endcase
        if (wave_mode_select == 4'h4 || wave_mode_select == 4'h9 || wave_mode_select == 4'hb
            || wave_mode_select == 4'hf)
            mode.topsrc = tmw_pkg::TMW_TOP_CMPA;
        else if (wave_mode_select == 4'h8 || wave_mode_select == 4'ha
            || wave_mode_select == 4'hc || wave_mode_select == 4'he)
            mode.topsrc = tmw_pkg::TMW_TOP_CAP;
    end

    assign top = (mode.topsrc == tmw_pkg::TMW_TOP_CMPA) ? cmpa_reg
               : (mode.topsrc == tmw_pkg::TMW_TOP_CAP) ? cap_reg : mode.fixed_top;

    assign capture_input_enable = (mode.topsrc != tmw_pkg::TMW_TOP_CAP);
    assign ext_fall = ext_reg & ~ext_clk_pin;
    assign ext_rise = ~ext_reg & ext_clk_pin;
    assign cap_edge = capture_input_enable & cap_pin_reg & ~capture_input_pin;

    always_comb
    begin
        unique case (clock_source_select)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = (pre_reg[2:0] == 3'h7);
            3'h3: tick = (pre_reg[5:0] == 6'h3f);
            3'h4: tick = (pre_reg[7:0] == 8'hff);
            3'h5: tick = (pre_reg == tmw_pkg::PRESCALE_MAX);
            3'h6: tick = ext_fall;
            default: tick = ext_rise;
        endcase
    end

    assign at_top = (cnt_reg == top);
    assign at_bottom = (cnt_reg == 16'h0000);
    assign match_a = tick & ~block_reg & (cnt_reg == cmpa_reg);
    assign match_b = tick & ~block_reg & (cnt_reg == cmpb_reg);
    assign ovf_evt = tick & (mode.ovf_at_bottom ? (at_bottom & down_reg)
                   : (mode.kind == tmw_pkg::TMW_FAST ? at_top : cnt_reg == tmw_pkg::TOP_MAX));

    // Waveform action for one channel given its mode field.
    function automatic logic wave_step(input logic cur, input logic [1:0] om,
                                       input logic m, input logic is_a,
                                       input tmw_pkg::tmw_mode_t md, input logic down,
                                       input logic bottom_tick, input logic top_eq);
        logic r;
        r = cur;
        if (md.kind == tmw_pkg::TMW_NORMAL || md.kind == tmw_pkg::TMW_CTC)
        begin
            if (m)
                r = (om == 2'h1) ? ~cur : om[0];
        end
        else if (om == 2'h1)
        begin
            if (m && md.topsrc != tmw_pkg::TMW_TOP_FIXED && is_a)
                r = ~cur;
        end
        else if (md.kind == tmw_pkg::TMW_FAST)
        begin
            if (bottom_tick)
                r = ~om[0];
            if (m && !top_eq)
                r = om[0];
        end
        else if (m)
            r = down ? ~om[0] : om[0];
        return r;
    endfunction

    always_comb
    begin
        cnt_next = cnt_reg;
        down_next = down_reg;
        bufa_next = bufa_reg;
        bufb_next = bufb_reg;
        cap_next = cap_reg;
        cmpa_next = cmpa_reg;
        cmpb_next = cmpb_reg;
        hold_next = hold_reg;
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        block_next = 1'b0;
        pre_next = (clock_source_select == 3'h0) ? 10'h000 : pre_reg + 10'h001;
        ext_next = ext_clk_pin;
        cap_pin_next = capture_input_pin;
        if (tick)
        begin
            if (mode.kind == tmw_pkg::TMW_PHASE)
            begin
                if (at_top)
                    down_next = 1'b1;
                else if (at_bottom)
                    down_next = 1'b0;
                cnt_next = (at_top || (down_reg && !at_bottom)) ? cnt_reg - 16'h0001
                         : cnt_reg + 16'h0001;
            end
            else
                cnt_next = (mode.kind != tmw_pkg::TMW_NORMAL && at_top) ? 16'h0000
                         : cnt_reg + 16'h0001;
            if ((mode.upd == tmw_pkg::TMW_UPD_TOP && at_top)
                || (mode.upd == tmw_pkg::TMW_UPD_BOTTOM && at_bottom))
            begin
                cmpa_next = bufa_reg;
                cmpb_next = bufb_reg;
            end
        end
        if (cap_edge)
            cap_next = cnt_reg;
        if (bus.wr)
        begin
            unique case (bus.addr)
                tmw_pkg::OFS_CTRL_A: ctrl_a_next = bus.wdata;
                tmw_pkg::OFS_CTRL_B: ctrl_b_next = bus.wdata & tmw_pkg::CTRL_B_WMASK;
                tmw_pkg::OFS_CNT_H, tmw_pkg::OFS_CMPA_H, tmw_pkg::OFS_CMPB_H, tmw_pkg::OFS_CAP_H:
                    hold_next = bus.wdata;
                tmw_pkg::OFS_CNT_L:
                begin
                    cnt_next = {hold_reg, bus.wdata};
                    block_next = 1'b1;
                end
                tmw_pkg::OFS_CMPA_L: bufa_next = {hold_reg, bus.wdata};
                tmw_pkg::OFS_CMPB_L: bufb_next = {hold_reg, bus.wdata};
                tmw_pkg::OFS_CAP_L: cap_next = {hold_reg, bus.wdata};
                default: ;
            endcase
            if (mode.upd == tmw_pkg::TMW_UPD_NOW && bus.addr == tmw_pkg::OFS_CMPA_L)
                cmpa_next = {hold_reg, bus.wdata};
            if (mode.upd == tmw_pkg::TMW_UPD_NOW && bus.addr == tmw_pkg::OFS_CMPB_L)
                cmpb_next = {hold_reg, bus.wdata};
        end
        else if (bus.rd && bus.addr == tmw_pkg::OFS_CNT_L)
            hold_next = cnt_reg[15:8];
        else if (bus.rd && bus.addr == tmw_pkg::OFS_CAP_L)
            hold_next = cap_reg[15:8];
        // Fast PWM acts at bottom on the tick that wraps the counter from top to zero.
        wa_next = wave_step(wa_reg, chan_a_output_mode, match_a, 1'b1, mode, down_reg,
                            tick & at_top, cmpa_reg == top & chan_a_output_mode[1]);
        wb_next = wave_step(wb_reg, chan_b_output_mode, match_b, 1'b0, mode, down_reg,
                            tick & at_top, cmpb_reg == top & chan_b_output_mode[1]);
    end

    always_comb
    begin
        unique case (bus.addr)
            tmw_pkg::OFS_CTRL_A: rdata = ctrl_a_reg;
            tmw_pkg::OFS_CTRL_B: rdata = ctrl_b_reg;
            tmw_pkg::OFS_CNT_L: rdata = cnt_reg[7:0];
            tmw_pkg::OFS_CMPA_L: rdata = cmpa_reg[7:0];
            tmw_pkg::OFS_CMPA_H: rdata = cmpa_reg[15:8];
            tmw_pkg::OFS_CMPB_L: rdata = cmpb_reg[7:0];
            tmw_pkg::OFS_CMPB_H: rdata = cmpb_reg[15:8];
            tmw_pkg::OFS_CAP_L: rdata = cap_reg[7:0];
            tmw_pkg::OFS_CNT_H, tmw_pkg::OFS_CAP_H: rdata = hold_reg;
            default: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ctrl_a_reg <= tmw_pkg::CTRL_A_RESET;
            ctrl_b_reg <= tmw_pkg::CTRL_B_RESET;
            hold_reg <= 8'h00;
            cnt_reg <= 16'h0000;
            cmpa_reg <= 16'h0000;
            cmpb_reg <= 16'h0000;
            bufa_reg <= 16'h0000;
            bufb_reg <= 16'h0000;
            cap_reg <= 16'h0000;
            pre_reg <= 10'h000;
            down_reg <= 1'b0;
            wa_reg <= 1'b0;
            wb_reg <= 1'b0;
            ext_reg <= 1'b0;
            cap_pin_reg <= 1'b0;
            block_reg <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else
        begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
            hold_reg <= hold_next;
            cnt_reg <= cnt_next;
            cmpa_reg <= cmpa_next;
            cmpb_reg <= cmpb_next;
            bufa_reg <= bufa_next;
            bufb_reg <= bufb_next;
            cap_reg <= cap_next;
            pre_reg <= pre_next;
            down_reg <= down_next;
            wa_reg <= wa_next;
            wb_reg <= wb_next;
            ext_reg <= ext_next;
            cap_pin_reg <= cap_pin_next;
            block_reg <= block_next;
            overflow_flag <= ovf_evt;
        end
    end

    assign wave_out_a = wa_reg;
    assign wave_out_b = wb_reg;
    assign wave_a_pin_override = |chan_a_output_mode;
    assign wave_b_pin_override = |chan_b_output_mode;

    a_hold_latch: assert property (@(posedge core_clk) disable iff (!nrst)
        bus.rd && !bus.wr && bus.addr == tmw_pkg::OFS_CNT_L
        |=> hold_reg == $past(cnt_reg[15:8])) else $error("holding byte not latched");
    a_hold_keep: assert property (@(posedge core_clk) disable iff (!nrst)
        bus.wr && bus.addr == tmw_pkg::OFS_CMPB_L |=> $stable(hold_reg))
        else $error("holding byte lost on low write");
    a_cnt_load: assert property (@(posedge core_clk) disable iff (!nrst)
        bus.wr && bus.addr == tmw_pkg::OFS_CNT_L
        |=> cnt_reg == {$past(hold_reg), $past(bus.wdata)}) else $error("count load wrong");
    a_override_a: assert property (@(posedge core_clk) disable iff (!nrst)
        bus.wr && bus.addr == tmw_pkg::OFS_CTRL_A && bus.wdata[7:6] != 2'h0
        |=> wave_a_pin_override) else $error("override a wrong");
    a_ctrlb_bit5: assert property (@(posedge core_clk) disable iff (!nrst)
        !ctrl_b_reg[5]) else $error("control b bit 5 set");
    a_cap_disc: assert property (@(posedge core_clk) disable iff (!nrst)
        wave_mode_select == 4'hc |-> !capture_input_enable) else $error("capture pin live");
    sequence s_stopped_pair;
        clock_source_select == 3'h0 && !bus.wr ##1 clock_source_select == 3'h0;
    endsequence
    a_stop_cnt: assert property (@(posedge core_clk) disable iff (!nrst)
        s_stopped_pair |-> $stable(cnt_reg)) else $error("stopped counter moved");
    a_norm_ovf: assert property (@(posedge core_clk) disable iff (!nrst)
        wave_mode_select == 4'h0 && tick && cnt_reg == 16'hffff |=> overflow_flag)
        else $error("normal overflow missed");
endmodule
`default_nettype wire

/* File: tmw_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Processor side of the register bus. Waveform pins are taken as outputs here,
// since pin direction lies outside this block.
module tmw_cpu_model (
    input wire logic core_clk,
    output var tmw_pkg::tmw_bus_t bus,
    input wire logic [7:0] rdata
);
    initial bus = '0;

    // Entered just after a rising edge; the strobe lasts one cycle.
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
        output logic [7:0] q);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
        q = rdata;
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        @(posedge core_clk);
    endtask

    // Both halves run with nothing in between, as with interrupts masked.
    task automatic w16(input logic [5:0] lo, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, lo + 6'h01, v[15:8], q);
        acc(1'b1, lo, v[7:0], q);
    endtask

    task automatic r16(input logic [5:0] lo, output logic [15:0] v);
        acc(1'b0, lo, 8'h00, v[7:0]);
        acc(1'b0, lo + 6'h01, 8'h00, v[15:8]);
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ext_clk_pin = 1'b0;
    logic capture_input_pin = 1'b1;
    tmw_pkg::tmw_bus_t bus;
    logic [7:0] rdata;
    logic wave_out_a, wave_out_b, wave_a_pin_override, wave_b_pin_override;
    logic overflow_flag, capture_input_enable;
    int n_mismatch = 0;
    int num_checks = 0;

    always #50 core_clk = ~core_clk;

    tmw_timer i_dut (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
        .ext_clk_pin(ext_clk_pin), .capture_input_pin(capture_input_pin),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
        .wave_a_pin_override(wave_a_pin_override),
        .wave_b_pin_override(wave_b_pin_override), .overflow_flag(overflow_flag),
        .capture_input_enable(capture_input_enable));
    tmw_cpu_model i_cpu (.core_clk(core_clk), .bus(bus), .rdata(rdata));

    task automatic results();
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_cpu.acc(1'b1, a, d, q);
    endtask

    task automatic hi_cnt(input int n, output int ca, output int cb);
        ca = 0;
        cb = 0;
        repeat (n)
        begin
            @(negedge core_clk);
            ca += int'(wave_out_a === 1'b1);
            cb += int'(wave_out_b === 1'b1);
        end
        @(posedge core_clk);
    endtask

    // Cycles between two overflow pulses, or between two changes of output A.
    task automatic gap(input logic ovf, output int n);
        logic p;
        repeat (2)
        begin
            p = wave_out_a;
            n = 0;
            do
            begin
                @(negedge core_clk);
                n++;
            end
            while (n < 3000 && (ovf ? overflow_flag !== 1'b1 : wave_out_a === p));
        end
        @(posedge core_clk);
    endtask

    task automatic t_reset();
        logic [7:0] q;
        i_cpu.acc(1'b0, tmw_pkg::OFS_CTRL_B, 8'h00, q);
        chk("ctrl b reset", {8'h00, q}, 16'h0000);
        i_cpu.acc(1'b0, tmw_pkg::OFS_CTRL_A, 8'h00, q);
        chk("ctrl a reset", {8'h00, q}, 16'h0000);
        wr(tmw_pkg::OFS_CTRL_B, 8'hff);
        i_cpu.acc(1'b0, tmw_pkg::OFS_CTRL_B, 8'h00, q);
        chk("ctrl b spare bit", {8'h00, q}, 16'h00df);
        i_cpu.acc(1'b0, 6'h30, 8'h00, q);
        chk("unmapped", {8'h00, q}, 16'h0000);
    endtask

    task automatic t_cap();
        logic [7:0] ma[6] = '{8'h00, 8'h02, 8'h00, 8'h02, 8'h03, 8'h00};
        logic [7:0] mb[6] = '{8'h18, 8'h18, 8'h10, 8'h10, 8'h18, 8'h08};
        for (int i = 0; i < 6; i++)
        begin
            wr(tmw_pkg::OFS_CTRL_A, ma[i]);
            wr(tmw_pkg::OFS_CTRL_B, mb[i]);
            chk("capture enable", {15'h0, capture_input_enable}, 16'(i > 3));
        end
        wr(tmw_pkg::OFS_CTRL_B, 8'h00);
        wr(tmw_pkg::OFS_CTRL_A, 8'h00);
    endtask

    task automatic t_pair();
        logic [15:0] v;
        i_cpu.w16(tmw_pkg::OFS_CNT_L, 16'h01ff);
        i_cpu.r16(tmw_pkg::OFS_CNT_L, v);
        chk("count", v, 16'h01ff);
        wr(tmw_pkg::OFS_CNT_H, 8'h12);
        wr(tmw_pkg::OFS_CMPA_L, 8'h34);
        wr(tmw_pkg::OFS_CMPB_L, 8'h56);
        i_cpu.r16(tmw_pkg::OFS_CMPA_L, v);
        chk("cmp a", v, 16'h1234);
        i_cpu.r16(tmw_pkg::OFS_CMPB_L, v);
        chk("cmp b", v, 16'h1256);
        wr(tmw_pkg::OFS_CNT_H, 8'hab);
        i_cpu.acc(1'b0, tmw_pkg::OFS_CNT_L, 8'h00, v[7:0]);
        wr(tmw_pkg::OFS_CMPA_L, 8'h00);
        i_cpu.r16(tmw_pkg::OFS_CMPA_L, v);
        chk("shared hold", v, 16'h0100);
        capture_input_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
        capture_input_pin <= 1'b1;
        @(posedge core_clk);
        i_cpu.r16(tmw_pkg::OFS_CAP_L, v);
        chk("capture", v, 16'h01ff);
    endtask

    task automatic t_ovr();
        for (int m = 0; m < 4; m++)
        begin
            wr(tmw_pkg::OFS_CTRL_A, {m[1:0], m[1:0], 4'h0});
            chk("override a", {15'h0, wave_a_pin_override}, 16'(m != 0));
            chk("override b", {15'h0, wave_b_pin_override}, 16'(m != 0));
        end
    endtask

    task automatic t_clk();
        logic [15:0] v;
        for (int e = 6; e < 8; e++)
        begin
            i_cpu.w16(tmw_pkg::OFS_CNT_L, 16'h0000);
            wr(tmw_pkg::OFS_CTRL_B, 8'(e));
            repeat (5)
            begin
                repeat (2) @(posedge core_clk);
                ext_clk_pin <= 1'b1;
                repeat (2) @(posedge core_clk);
                ext_clk_pin <= 1'b0;
            end
            repeat (2) @(posedge core_clk);
            wr(tmw_pkg::OFS_CTRL_B, 8'h00);
            i_cpu.r16(tmw_pkg::OFS_CNT_L, v);
            chk("external count", v, 16'h0005);
        end
    endtask

    task automatic t_ctc();
        int n;
        i_cpu.w16(tmw_pkg::OFS_CMPA_L, 16'h0009);
        wr(tmw_pkg::OFS_CTRL_A, 8'h40);
        wr(tmw_pkg::OFS_CTRL_B, 8'h0a);
        gap(1'b0, n);
        chk("toggle gap div 8", 16'(n), 16'h0050);
        wr(tmw_pkg::OFS_CTRL_B, 8'h09);
        gap(1'b0, n);
        chk("toggle gap", 16'(n), 16'h000a);
        for (int c = 2; c < 4; c++)
        begin
            wr(tmw_pkg::OFS_CTRL_A, 8'(c << 6));
            repeat (30) @(posedge core_clk);
            chk("match level", {15'h0, wave_out_a}, 16'(c - 2));
        end
        wr(tmw_pkg::OFS_CTRL_B, 8'h00);
        wr(tmw_pkg::OFS_CTRL_A, 8'h40);
        i_cpu.w16(tmw_pkg::OFS_CNT_L, 16'h0000);
        i_cpu.w16(tmw_pkg::OFS_CMPA_L, 16'h0003);
        i_cpu.w16(tmw_pkg::OFS_CAP_L, 16'h0004);
        wr(tmw_pkg::OFS_CTRL_B, 8'h19);
        gap(1'b0, n);
        chk("capture top gap", 16'(n), 16'h0005);
        wr(tmw_pkg::OFS_CTRL_B, 8'h00);
        wr(tmw_pkg::OFS_CTRL_A, 8'h00);
        i_cpu.w16(tmw_pkg::OFS_CNT_L, 16'hfff0);
        wr(tmw_pkg::OFS_CTRL_B, 8'h01);
        n = 0;
        while (n < 40 && overflow_flag !== 1'b1)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("overflow at max", 16'(n < 40), 16'h0001);
    endtask

    task automatic t_pwm();
        int n, ca, cb;
        wr(tmw_pkg::OFS_CTRL_B, 8'h00);
        i_cpu.w16(tmw_pkg::OFS_CMPA_L, 16'h0040);
        i_cpu.w16(tmw_pkg::OFS_CMPB_L, 16'h0040);
        i_cpu.w16(tmw_pkg::OFS_CNT_L, 16'h0000);
        wr(tmw_pkg::OFS_CTRL_A, 8'hb1);
        wr(tmw_pkg::OFS_CTRL_B, 8'h09);
        gap(1'b1, n);
        chk("fast period", 16'(n), 16'h0100);
        hi_cnt(256, ca, cb);
        chk("fast a high", 16'(ca), 16'h0041);
        chk("fast b high", 16'(cb), 16'h00bf);
        i_cpu.w16(tmw_pkg::OFS_CMPA_L, 16'h00ff);
        repeat (600) @(posedge core_clk);
        hi_cnt(256, ca, cb);
        chk("compare at top", 16'(ca), 16'h0100);
        i_cpu.w16(tmw_pkg::OFS_CMPA_L, 16'h0040);
        wr(tmw_pkg::OFS_CTRL_B, 8'h01);
        repeat (1200) @(posedge core_clk);
        gap(1'b1, n);
        chk("phase period", 16'(n), 16'h01fe);
        hi_cnt(510, ca, cb);
        chk("phase a high", 16'(ca), 16'h0080);
        chk("phase b high", 16'(cb), 16'h017e);
        wr(tmw_pkg::OFS_CTRL_B, 8'h00);
        wr(tmw_pkg::OFS_CTRL_A, 8'h40);
        i_cpu.w16(tmw_pkg::OFS_CMPA_L, 16'h0020);
        i_cpu.w16(tmw_pkg::OFS_CNT_L, 16'h0000);
        wr(tmw_pkg::OFS_CTRL_A, 8'h41);
        wr(tmw_pkg::OFS_CTRL_B, 8'h11);
        repeat (1200) @(posedge core_clk);
        gap(1'b1, n);
        chk("dual slope period", 16'(n), 16'h0040);
        gap(1'b0, n);
        chk("toggle at top", 16'(n), 16'h0040);
        wr(tmw_pkg::OFS_CTRL_B, 8'h01);
        hi_cnt(600, ca, cb);
        chk("output held", 16'(ca == 0 || ca == 600), 16'h0001);
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        chk("capture enable reset", {15'h0, capture_input_enable}, 16'h0001);
        t_reset();
        t_cap();
        t_pair();
        t_ovr();
        t_clk();
        t_ctc();
        t_pwm();
        results();
    end

    initial
    begin
        repeat (30000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
